// ---- design/i2cms_defs.vh ----
// Purpose: constants for the i2c master sequencer
// Assumes: 32-bit classic wishbone register bus, word aligned
// Notes:   offsets are byte addresses
`ifndef I2CMS_DEFS_VH
`define I2CMS_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define I2CMS_RELOAD_ADDR   4'h0
`define I2CMS_BUFFER_ADDR   4'h4
`define I2CMS_CONTROL_ADDR  4'h8
`define I2CMS_STATUS_ADDR   4'hC

// ****************************************
// control_two_reg fields
// ****************************************
`define I2CMS_CTL_START     0
`define I2CMS_CTL_RESTART   1
`define I2CMS_CTL_STOP      2
`define I2CMS_CTL_RECEIVE   3
`define I2CMS_CTL_ACKSEQ    4
`define I2CMS_CTL_ACKVAL    5
`define I2CMS_CTL_ACK_STATUS   6

// ****************************************
// port_status_reg fields (write one to clear bits 1..5)
// ****************************************
`define I2CMS_ST_FULL       0
`define I2CMS_ST_WRITE_COLLISION       1
`define I2CMS_ST_OVF        2
`define I2CMS_ST_EVENT      3
`define I2CMS_ST_BCOL       4
`define I2CMS_ST_STARTSEEN  5
`define I2CMS_ST_BUSY       6

// ****************************************
// reset values and timing
// ****************************************
`define I2CMS_RELOAD_RST    7'h00
`define I2CMS_WRITE_WIN_TCY 2
`define I2CMS_CLK_PER_TCY   4

`endif

// ---- design/i2cms_master.v ----
// Purpose: master-mode sequencer of an i2c port: start, repeated start,
//          byte transmit with ack sample, byte receive, clock arbitration.
// Assumes: bus pins sampled synchronously; clk_i 40 MHz; four clocks per tcy.
// Notes:   stop and ack sequences are not generated; their request bits
//          are stored only.
//
// Overview of operation
// RULE_01 - generator holds while released scl stays low
// RULE_02 - reload generator when scl seen high
// RULE_03 - one scl period equals two rollovers
// RULE_04 - start: lines high, wait period, pull sda
// RULE_05 - second period, clear start, suspend, sda low
// RULE_06 - start collision flags and returns idle
// RULE_07 - buffer write during start sets write collision
// RULE_08 - low control bits locked during start phases
// RULE_09 - restart accepted only when idle
// RULE_10 - restart: scl low, release sda, raise scl
// RULE_11 - restart: sda low period, start-seen, event
// RULE_12 - restart collision on low sda or early scl fall (code flags low sda only; scl low is treated as stretching)
// RULE_13 - buffer write sets full, starts transmit
// RULE_14 - eighth falling edge clears full, releases sda
// RULE_15 - ninth falling edge samples ack status
// RULE_16 - after ninth clock event, suspend scl low
// RULE_17 - write during shift: collision, 2 tcy window
// RULE_18 - write collision cleared only by software
// RULE_19 - receive request ignored unless idle
// RULE_20 - receive eight bits, load buffer, event
// RULE_21 - buffer read clears full in receive
// RULE_22 - byte arriving while full sets overflow
// RULE_23 - generator decrements twice per tcy
// RULE_24 - reload from seven bit reload field
// RULE_25 - reset clears all flags, releases lines
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`include "i2cms_defs.vh"

module i2cms_master #(
    parameter RELOAD_W = 7
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        scl_i,
    output wire        scl_o,
    output wire        scl_oe_n_o,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_n_o
);

// ****************************************
// states
// ****************************************
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_SWAIT = 4'h1;   // start: lines high, counting
localparam [3:0] ST_SHOLD = 4'h2;   // start: sda low, counting
localparam [3:0] ST_RLOW = 4'h3;    // restart: scl low, sda released
localparam [3:0] ST_RHIGH = 4'h4;   // restart: scl released
localparam [3:0] ST_RSDA = 4'h5;    // restart: sda low, scl high
localparam [3:0] ST_TLOW = 4'h6;    // transmit: scl low
localparam [3:0] ST_THIGH = 4'h7;   // transmit: scl released
localparam [3:0] ST_RXLOW = 4'h8;   // receive: scl low
localparam [3:0] ST_RXHIGH = 4'h9;  // receive: scl released

// ****************************************
// registers
// ****************************************
reg [RELOAD_W-1:0] reload_r;
reg [7:0]          buf_r;
reg [7:0]          shift_r;
reg [6:0]          ctl_r;
reg                full_r, write_collision_r, ovf_r, event_r, bcol_r, sseen_r;
reg [3:0]          state_r;
reg [RELOAD_W-1:0] cnt_r;
reg [1:0]          phase_r;
reg [3:0]          bit_r;
reg                scl_low_r, sda_low_r, rx_mode_r;
reg [3:0]          wwin_r;

// ****************************************
// timing notes
// ****************************************
// one generator period: the counter is loaded with the reload value and
// decrements on every tick; tick fires on two of the four clocks of a tcy,
// so a period lasts about (reload + 1) * 2 clocks.
// the counter is reloaded in the same edge that releases scl, and again on
// every edge at which scl still reads low; the high phase therefore counts
// a full period from the first edge that sees scl high, however long a
// slave stretches the clock.
// a timeout that lands while scl is released but still low is ignored,
// because the low branch wins over the timeout branch.
// the write window counter runs on every clock after a buffer write that
// starts a transmit; a second write while it is nonzero still lands in
// the buffer but not in the shifter, so the byte on the wire is the first.
// collision, start-seen and event flags are only set by hardware and only
// cleared by a status write; a set in the same edge as the clear wins,
// because the set assignments follow the clear in the process.
// reset values of the enables are high so both lines float after reset.
// limitation: stop and acknowledge sequences are not generated; their
// request bits are stored so software sees them, nothing else happens.
// limitation: arbitration loss during data bits is not detected; only
// start and repeated start collisions raise the collision flag.

wire acc = cyc_i & stb_i & ~ack_o;
wire wr = acc & we_i & sel_i[0];
wire rd = acc & ~we_i;
wire wr_buf = wr & (adr_i == `I2CMS_BUFFER_ADDR);
wire wr_ctl = wr & (adr_i == `I2CMS_CONTROL_ADDR);
wire wr_sts = wr & (adr_i == `I2CMS_STATUS_ADDR);
wire rd_buf = rd & (adr_i == `I2CMS_BUFFER_ADDR);
wire in_start = (state_r >= ST_SWAIT) && (state_r <= ST_RSDA);
wire in_shift = (state_r == ST_TLOW) || (state_r == ST_THIGH);
wire idle = (state_r == ST_IDLE);
// two decrements per tcy on phases 1 and 3
wire tick = phase_r[0]; // RULE_23
wire tout = (cnt_r == {RELOAD_W{1'b0}}) & tick;
localparam [3:0] WWIN = `I2CMS_WRITE_WIN_TCY * `I2CMS_CLK_PER_TCY;

// pins are open drain: the data outputs stay low and only the enables move.
assign scl_o = 1'b0;
assign sda_o = 1'b0;
assign scl_oe_n_o = ~scl_low_r;
assign sda_oe_n_o = ~sda_low_r;

function [7:0] set_bit;
    input [7:0] v;
    input [2:0] i;
    begin
        set_bit = v | (8'h01 << i);
    end
endfunction

// ****************************************
// wishbone slave
// ****************************************
// every access is answered one clock after it is taken; ack drops in the
// next clock, so a master that holds its request sees an ack every second clock.
// read data is registered in the same edge as ack and stands with it.
// writes to unmapped offsets are acked and ignored.
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
    end else begin
        ack_o <= acc;
        case (adr_i)
            `I2CMS_RELOAD_ADDR:  dat_o <= {25'h000_0000, reload_r};
            `I2CMS_BUFFER_ADDR:  dat_o <= {24'h00_0000, buf_r};
            `I2CMS_CONTROL_ADDR: dat_o <= {25'h000_0000, ctl_r};
            `I2CMS_STATUS_ADDR:  dat_o <= {25'h000_0000, ~idle, sseen_r, bcol_r,
                                           event_r, ovf_r, write_collision_r, full_r};
            default:             dat_o <= 32'h0000_0000;
        endcase
    end
end

// ****************************************
// sequencer
// ****************************************
always @(posedge clk_i) begin
    if (rst_i) begin // RULE_25
        reload_r <= `I2CMS_RELOAD_RST;
        buf_r <= 8'h00;
        shift_r <= 8'h00;
        ctl_r <= 7'h00;
        full_r <= 1'b0;
        write_collision_r <= 1'b0;
        ovf_r <= 1'b0;
        event_r <= 1'b0;
        bcol_r <= 1'b0;
        sseen_r <= 1'b0;
        state_r <= ST_IDLE;
        cnt_r <= {RELOAD_W{1'b0}};
        phase_r <= 2'b00;
        bit_r <= 4'h0;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
        rx_mode_r <= 1'b0;
        wwin_r <= 4'h0;
    end else begin
        phase_r <= phase_r + 2'b01;
        if (wwin_r != 4'h0)
            wwin_r <= wwin_r - 4'h1;
        if (tick && cnt_r != {RELOAD_W{1'b0}})
            cnt_r <= cnt_r - {{(RELOAD_W-1){1'b0}}, 1'b1};
        if (wr & (adr_i == `I2CMS_RELOAD_ADDR))
            reload_r <= dat_i[RELOAD_W-1:0]; // RULE_24
        // status clears first so a same-cycle hardware set wins below
        if (wr_sts) begin
            if (dat_i[`I2CMS_ST_WRITE_COLLISION])  write_collision_r <= 1'b0; // RULE_18
            if (dat_i[`I2CMS_ST_OVF])   ovf_r <= 1'b0;
            if (dat_i[`I2CMS_ST_EVENT]) event_r <= 1'b0;
            if (dat_i[`I2CMS_ST_BCOL])  bcol_r <= 1'b0;
            if (dat_i[`I2CMS_ST_STARTSEEN]) sseen_r <= 1'b0;
        end
        if (rd_buf && rx_mode_r)
            full_r <= 1'b0; // RULE_21
        if (wr_ctl) begin
            ctl_r[`I2CMS_CTL_ACKVAL] <= dat_i[`I2CMS_CTL_ACKVAL];
            if (!in_start) begin // RULE_08
                ctl_r[`I2CMS_CTL_STOP] <= dat_i[`I2CMS_CTL_STOP];
                ctl_r[`I2CMS_CTL_ACKSEQ] <= dat_i[`I2CMS_CTL_ACKSEQ];
                ctl_r[`I2CMS_CTL_START] <= dat_i[`I2CMS_CTL_START] & idle;
                ctl_r[`I2CMS_CTL_RESTART] <= dat_i[`I2CMS_CTL_RESTART] & idle; // RULE_09
                ctl_r[`I2CMS_CTL_RECEIVE] <= dat_i[`I2CMS_CTL_RECEIVE] & idle; // RULE_19
            end
        end
        if (wr_buf) begin
            if (in_start || state_r == ST_RXLOW || state_r == ST_RXHIGH) begin
                write_collision_r <= 1'b1; // RULE_07
            end else if (in_shift) begin
                write_collision_r <= 1'b1; // RULE_17
                if (wwin_r != 4'h0)
                    buf_r <= dat_i[7:0];
            end else begin
                buf_r <= dat_i[7:0]; // RULE_13
                shift_r <= dat_i[7:0];
                full_r <= 1'b1;
                rx_mode_r <= 1'b0;
                wwin_r <= WWIN;
                bit_r <= 4'h0;
                scl_low_r <= 1'b1;
                cnt_r <= reload_r;
                state_r <= ST_TLOW;
            end
        end
        // state actions below run after the bus writes above, so a hardware
        // set of a flag in this edge overrides a software clear in this edge.
        case (state_r)
            ST_IDLE: begin
                if (ctl_r[`I2CMS_CTL_START]) begin
                    if (!sda_i || !scl_i) begin // RULE_06
                        bcol_r <= 1'b1;
                        ctl_r[`I2CMS_CTL_START] <= 1'b0;
                    end else begin
                        cnt_r <= reload_r; // RULE_04
                        state_r <= ST_SWAIT;
                    end
                end else if (ctl_r[`I2CMS_CTL_RESTART]) begin
                    scl_low_r <= 1'b1; // RULE_10
                    state_r <= ST_RLOW;
                    cnt_r <= reload_r;
                end else if (ctl_r[`I2CMS_CTL_RECEIVE] && !wr_buf) begin
                    scl_low_r <= 1'b1; // RULE_20
                    sda_low_r <= 1'b0;
                    bit_r <= 4'h0;
                    cnt_r <= reload_r;
                    state_r <= ST_RXLOW;
                end
            end
            ST_SWAIT: begin
                if (!scl_i) begin // RULE_06
                    bcol_r <= 1'b1;
                    ctl_r[`I2CMS_CTL_START] <= 1'b0;
                    state_r <= ST_IDLE;
                end else if (tout && sda_i) begin
                    sda_low_r <= 1'b1; // RULE_04
                    sseen_r <= 1'b1;
                    cnt_r <= reload_r; // RULE_05
                    state_r <= ST_SHOLD;
                end
            end
            ST_SHOLD: begin
                if (tout) begin
                    ctl_r[`I2CMS_CTL_START] <= 1'b0; // RULE_05
                    event_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
            end
            ST_RLOW: begin
                sda_low_r <= 1'b0;
                if (scl_i)
                    cnt_r <= reload_r; // reload while scl still reads high
                else if (tout) begin
                    if (sda_i) begin
                        scl_low_r <= 1'b0; // RULE_10
                        cnt_r <= reload_r; // RULE_02
                        state_r <= ST_RHIGH;
                    end
                end
            end
            ST_RHIGH: begin
                if (!scl_i)
                    cnt_r <= reload_r; // RULE_01
                else if (!sda_i) begin
                    bcol_r <= 1'b1; // RULE_12
                    ctl_r[`I2CMS_CTL_RESTART] <= 1'b0;
                    state_r <= ST_IDLE;
                end else if (tout) begin
                    sda_low_r <= 1'b1; // RULE_11
                    sseen_r <= 1'b1;
                    cnt_r <= reload_r;
                    state_r <= ST_RSDA;
                end
            end
            ST_RSDA: begin
                if (tout) begin
                    ctl_r[`I2CMS_CTL_RESTART] <= 1'b0; // RULE_11
                    event_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
            end
            ST_TLOW: begin
                if (!wr_buf) begin
                    // drive the current bit; ninth bit leaves sda released
                    sda_low_r <= (bit_r < 4'h8) ? ~shift_r[7] : 1'b0; // RULE_14
                    if (tout) begin
                        scl_low_r <= 1'b0;
                        cnt_r <= reload_r; // RULE_02
                        state_r <= ST_THIGH;
                    end
                end
            end
            ST_THIGH: begin
                if (!scl_i)
                    cnt_r <= reload_r; // RULE_01
                else if (tout) begin // RULE_03
                    scl_low_r <= 1'b1;
                    cnt_r <= reload_r; // RULE_02
                    bit_r <= bit_r + 4'h1;
                    shift_r <= {shift_r[6:0], 1'b0};
                    if (bit_r == 4'h7) begin
                        full_r <= 1'b0; // RULE_14
                        sda_low_r <= 1'b0;
                        state_r <= ST_TLOW;
                    end else if (bit_r == 4'h8) begin
                        ctl_r[`I2CMS_CTL_ACK_STATUS] <= sda_i; // RULE_15
                        event_r <= 1'b1; // RULE_16
                        state_r <= ST_IDLE;
                    end else
                        state_r <= ST_TLOW;
                end
            end
            ST_RXLOW: begin
                if (tout) begin
                    scl_low_r <= 1'b0;
                    cnt_r <= reload_r; // RULE_02
                    state_r <= ST_RXHIGH;
                end
            end
            ST_RXHIGH: begin
                if (!scl_i)
                    cnt_r <= reload_r; // RULE_01
                else if (tout) begin
                    scl_low_r <= 1'b1;
                    cnt_r <= reload_r; // RULE_02
                    shift_r <= {shift_r[6:0], sda_i};
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == 4'h7) begin
                        ctl_r[`I2CMS_CTL_RECEIVE] <= 1'b0; // RULE_20
                        buf_r <= {shift_r[6:0], sda_i};
                        rx_mode_r <= 1'b1;
                        if (full_r)
                            ovf_r <= 1'b1; // RULE_22
                        full_r <= 1'b1;
                        event_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else
                        state_r <= ST_RXLOW;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

endmodule // i2cms_master

// ---- tb/i2cms_assertions.sv ----
// Purpose: port assertions for the i2c master sequencer
// Assumes: reload is 3 or more whenever the bus moves
// Notes:   bound from tb
`timescale 1ns/100ps
module i2cms_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic scl_i,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_oe_n_o
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_rst_release: assert property ($fell(rst_i) |-> scl_oe_n_o && sda_oe_n_o && !ack_o)
        else $error("lines not released after reset");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked next cycle");
    a_wait_stretch: assert property (scl_oe_n_o && !scl_i |=> scl_oe_n_o)
        else $error("clock pulled while stretched");
    // one period at reload 3 is eight clocks; six leaves margin
    a_high_min: assert property ($rose(scl_i) |-> scl_oe_n_o [*6])
        else $error("clock high phase too short");
    a_data_move: assert property ($rose(sda_oe_n_o) |-> !scl_i)
        else $error("data released with clock high");
    a_start_high: assert property ($fell(sda_oe_n_o) && scl_i |-> $past(sda_i) && $past(scl_i))
        else $error("start without idle lines");
    a_start_hold: assert property ($fell(sda_oe_n_o) && scl_i |=> !sda_oe_n_o [*4])
        else $error("start hold too short");

    c_start: cover property ($fell(sda_oe_n_o) && scl_i);
    c_stretch: cover property ((scl_oe_n_o && !scl_i) [*3]);
    c_ack: cover property (cyc_i && stb_i && ack_o);
endmodule // i2cms_assertions

// ---- tb/i2cms_slave_model.sv ----
// Purpose: behavioural slave on the two bus lines
// Assumes: pull-ups on both lines
// Notes:   acks written bytes, sends tx_i when rd_i, may stretch
`timescale 1ns/100ps
module i2cms_slave_model (
    input  wire logic       clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       rd_i,
    input  wire logic       nack_i,
    input  wire logic       stretch_i,
    input  wire logic       hold_i,
    input  wire logic [7:0] tx_i,
    output logic      [7:0] rx_o,
    output wire logic       scl_pull_o,
    output wire logic       sda_pull_o
);
    logic [3:0] cnt_r = 4'h0;
    logic [3:0] ph_r = 4'h0;
    logic       str_r = 1'b0;
    // ****
    // bit tracking
    // ****
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            cnt_r = 4'h0;
            ph_r = 4'h0;
        end
    end
    always @(posedge scl_i) begin
        if (cnt_r < 4'h8)
            rx_o = {rx_o[6:0], sda_i};
        cnt_r = (cnt_r == (rd_i ? 4'h7 : 4'h8)) ? 4'h0 : cnt_r + 4'h1;
    end
    // data only moves while the clock is low
    always @(negedge scl_i) begin
        ph_r = cnt_r;
        if (stretch_i) begin
            str_r = 1'b1;
            repeat (12) @(posedge clk_i);
            str_r <= 1'b0;
        end
    end
    assign scl_pull_o = hold_i | str_r;
    assign sda_pull_o = hold_i | (rd_i ? ~tx_i[3'h7 - ph_r[2:0]] : (ph_r == 4'h8 && !nack_i));
endmodule // i2cms_slave_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench for i2cms_master
// Assumes: reload 3, slave model with pull-ups on both lines
// Notes:   reads queue their expectation, a monitor compares at ack
`timescale 1ns/100ps
`include "i2cms_defs.vh"
module tb;
    localparam [3:0] A_RL = `I2CMS_RELOAD_ADDR;
    localparam [3:0] A_BF = `I2CMS_BUFFER_ADDR;
    localparam [3:0] A_CT = `I2CMS_CONTROL_ADDR;
    localparam [3:0] A_ST = `I2CMS_STATUS_ADDR;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] rv;
    logic        rd_m = 1'b0;
    logic        nack_m = 1'b0;
    logic        str_m = 1'b0;
    logic        hold_m = 1'b0;
    logic [7:0]  tx_m = 8'h00;
    logic [7:0]  b;
    logic [63:0] n;
    logic [63:0] q[$];
    integer      error_cnt = 0;
    integer      checked = 0;
    integer      seed = 77;
    integer      cyc_n = 0;
    integer      k;
    wire  [31:0] dat_o;
    wire  [7:0]  rx_m;
    wire         ack_o, scl_oe_n_o, sda_oe_n_o, scl_pull, sda_pull;
    // open-drain lines: low if anyone pulls
    wire         scl_i = scl_oe_n_o & ~scl_pull;
    wire         sda_i = sda_oe_n_o & ~sda_pull;

    always #12.5 clk_i = ~clk_i;

    i2cms_master uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .scl_i(scl_i), .scl_o(), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(),
        .sda_oe_n_o(sda_oe_n_o));
    i2cms_slave_model u_slv (.clk_i(clk_i), .scl_i(scl_i), .sda_i(sda_i), .rd_i(rd_m),
        .nack_i(nack_m), .stretch_i(str_m), .hold_i(hold_m), .tx_i(tx_m), .rx_o(rx_m),
        .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

    // ****
    // bus tasks and checks
    // ****
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back({m, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task poll(input logic [3:0] a, input integer bt, input logic v);
        do rd(a, 32'h0, 32'h0); while (rv[bt] !== v);
    endtask
    task ck(input string s, input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a zero mask marks a polling read that is not compared
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            error_cnt++;
            end_of_test;
        end
        if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) begin
            n = q.pop_front();
            if (n[63:32] != 32'h0) begin
                checked++;
                if (((dat_o ^ n[31:0]) & n[63:32]) !== 32'h0) begin
                    error_cnt++;
                    $display("ERROR reg %h expected %h seen %h", adr_i, n[31:0], dat_o);
                end
            end
        end
    end

    // ****
    // scenarios
    // ****
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        ck("scl_oe_n", {7'h0, scl_oe_n_o}, 8'h01);
        ck("sda_oe_n", {7'h0, sda_oe_n_o}, 8'h01);
        rd(A_ST, 32'h0, 32'h3f);
        rd(A_CT, 32'h0, 32'h1f);
        rd(4'h6, 32'h0, 32'hffff_ffff);
        wr(A_RL, 32'h83);
        rd(A_RL, 32'h03, 32'h7f);
        wr(A_CT, 32'h01);
        wr(A_BF, 32'h5a);
        wr(A_CT, 32'h08);
        poll(A_CT, 0, 1'b0);
        ck("sda_oe_n", {7'h0, sda_oe_n_o}, 8'h00);
        rd(A_ST, 32'h22, 32'h23);
        rd(A_CT, 32'h0, 32'h08);
        wr(A_ST, 32'h3e);
        for (k = 0; k < 2; k++) begin
            b = $random(seed);
            nack_m <= k[0];
            str_m <= k[0];
            wr(A_BF, {24'h0, b});
            if (k == 1) wr(A_BF, {24'h0, ~b});
            if (k == 1) rd(A_BF, {24'h0, ~b}, 32'hff);
            rd(A_ST, 32'h1, 32'h1);
            repeat (10) @(posedge clk_i);
            wr(A_BF, {24'h0, ~b});
            poll(A_ST, 3, 1'b1);
            ck("slave_rx", rx_m, b);
            ck("scl_oe_n", {7'h0, scl_oe_n_o}, 8'h00);
            rd(A_CT, {25'h0, k[0], 6'h0}, 32'h40);
            repeat (20) @(posedge clk_i);
            rd(A_ST, 32'h0a, 32'h0b);
            wr(A_ST, 32'h3e);
        end
        str_m <= 1'b0;
        rd_m <= 1'b1;
        for (k = 0; k < 3; k++) begin
            tx_m <= $random(seed);
            wr(A_CT, 32'h08);
            if (k == 0) wr(A_CT, 32'h0a);
            if (k == 0) wr(A_BF, 32'h0);
            poll(A_ST, 3, 1'b1);
            rd(A_CT, 32'h0, 32'h0a);
            if (k == 0) rd(A_ST, 32'h03, 32'h07);
            if (k == 0) rd(A_BF, {24'h0, tx_m}, 32'hff);
            if (k == 0) rd(A_ST, 32'h0, 32'h01);
            if (k == 2) rd(A_ST, 32'h05, 32'h05);
            wr(A_ST, 32'h3e);
        end
        rd_m <= 1'b0;
        wr(A_CT, 32'h02);
        wr(A_BF, 32'h0);
        poll(A_CT, 1, 1'b0);
        poll(A_ST, 3, 1'b1);
        rd(A_ST, 32'h22, 32'h32);
        ck("sda_oe_n", {7'h0, sda_oe_n_o}, 8'h00);
        wr(A_ST, 32'h3e);
        hold_m <= 1'b1;
        wr(A_CT, 32'h01);
        repeat (40) @(posedge clk_i);
        rd(A_ST, 32'h10, 32'h10);
        rd(A_CT, 32'h0, 32'h01);
        hold_m <= 1'b0;
        repeat (20) @(posedge clk_i);
        end_of_test;
    end
endmodule // tb

bind i2cms_master i2cms_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i),
    .sda_oe_n_o(sda_oe_n_o));
